// file: pkg/ssc_pkg.sv
package ssc_pkg;

  // ****************************************************************
  // Scaling and timing
  // ****************************************************************
  localparam int                 FS_BITS       = 14;
  localparam logic signed [15:0] FULL_SCALE    = 16'sh4000;
  localparam logic signed [15:0] MAG_MAX       = 16'sh7FFF;
  localparam int                 CLK_MHZ       = 125;
  localparam int                 TICK_US       = 10;
  localparam int                 TICK_CYCLES   = TICK_US * CLK_MHZ;
  localparam int                 MS_US         = 1000;
  localparam int                 CYCLES_PER_MS = MS_US * CLK_MHZ;
  localparam int                 CLEAR_MIN_MIN = 5;
  localparam int                 CLEAR_MIN_MS  = CLEAR_MIN_MIN * 60 * 1000;
  localparam int                 DELAY_MULT    = 4;
  localparam int                 GAIN_FRAC     = 8;
  localparam int                 DFILT_SHIFT   = 3;

  // ****************************************************************
  // Defaults
  // ****************************************************************
  localparam logic [7:0] FREQ_50HZ  = 8'h32;
  localparam logic [7:0] FREQ_60HZ  = 8'h3C;
  localparam logic [9:0] VOLT_230   = 10'h0E6;
  localparam logic [9:0] VOLT_400   = 10'h190;
  localparam logic [9:0] VOLT_460   = 10'h1CC;
  localparam logic [7:0] MENU_FIRST = 8'h01;
  localparam logic [7:0] MENU_NONE  = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOCK = 2'b10
  } ssc_rst_state_t;

  typedef enum logic {
    MIN_PROP   = 1'b0,
    MIN_LINEAR = 1'b1
  } ssc_min_mode_t;

  typedef struct packed {
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] kd;
    logic [14:0] limit;
  } ssc_loop_cfg_t;

  typedef struct packed {
    logic [15:0] centre;
    logic [15:0] width;
  } ssc_skip_cfg_t;

  typedef struct packed {
    logic        enable;
    logic [3:0]  maxAttempts;
    logic [15:0] delayMs;
  } ssc_restart_cfg_t;

endpackage : ssc_pkg

// file: logic/ssc_core.sv
module ssc_core #(
  parameter int MS_CYCLES = ssc_pkg::CYCLES_PER_MS
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic signed [15:0]       speedSetpoint,
  input  wire logic signed [15:0]       speedFeedback,
  input  wire logic                     loopEnable,
  input  wire ssc_pkg::ssc_loop_cfg_t   loopCfg,
  input  wire logic signed [15:0]       minSpeed,
  input  wire ssc_pkg::ssc_min_mode_t   minMode,
  input  wire ssc_pkg::ssc_skip_cfg_t [1:0] skipCfg,
  input  wire ssc_pkg::ssc_restart_cfg_t restartCfg,
  input  wire logic                     runInput,
  input  wire logic                     tripEvent,
  input  wire logic                     tripSelected,
  input  wire logic                     tripResetReq,
  input  wire logic                     keyStop,
  input  wire logic                     keyDown,
  input  wire logic                     keyUp,
  input  wire logic                     defaultFreqSel,
  input  wire logic                     build400V,
  output logic signed [15:0]            freqDemand,
  output logic                          tripped,
  output logic                          autoResetPulse,
  output logic [3:0]                    restartCount,
  output logic                          protectedMenu,
  output logic [7:0]                    menuEntry,
  output logic                          restoreDefaults,
  output logic [7:0]                    baseFreqHz,
  output logic [7:0]                    maxSpeedHz,
  output logic [9:0]                    motorVolts
);

  function automatic longint clampL(input longint v, input longint lo, input longint hi);
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : clampL

  // A value inside the band is pushed to the nearer edge so it is never held there.
  function automatic longint skipMag(input longint m, input ssc_pkg::ssc_skip_cfg_t b);
    longint lo;
    longint hi;
    lo = longint'(b.centre) - longint'(b.width >> 1);
    hi = longint'(b.centre) + longint'(b.width >> 1);
    if (b.centre == 16'h0000 || b.width == 16'h0000) return m;
    if (lo < 0) lo = 0;
    if (m > lo && m < hi) return (m < longint'(b.centre)) ? lo : hi;
    return m;
  endfunction : skipMag

  // ****************************************************************
  // Tick and millisecond dividers
  // ****************************************************************
  logic [10:0] tickCnt_reg, tickCnt_next;
  logic        tick_reg, tick_next;
  logic [16:0] msCnt_reg, msCnt_next;
  logic        ms_reg, ms_next;

  always_comb begin
    tick_next    = (tickCnt_reg == 11'(ssc_pkg::TICK_CYCLES - 1));
    tickCnt_next = tick_next ? 11'h000 : tickCnt_reg + 11'h001;
    ms_next      = (msCnt_reg == 17'(MS_CYCLES - 1));
    msCnt_next   = ms_next ? 17'h0_0000 : msCnt_reg + 17'h0_0001;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tickCnt_reg <= 11'h000;
      tick_reg    <= 1'b0;
      msCnt_reg   <= 17'h0_0000;
      ms_reg      <= 1'b0;
    end else begin
      tickCnt_reg <= tickCnt_next;
      tick_reg    <= tick_next;
      msCnt_reg   <= msCnt_next;
      ms_reg      <= ms_next;
    end
  end

  // ****************************************************************
  // Setpoint clamp, control loop and skip bands
  // ****************************************************************
  logic signed [15:0] intAcc_reg, intAcc_next;
  logic signed [16:0] errPrev_reg, errPrev_next;
  logic signed [17:0] dFilt_reg, dFilt_next;
  logic signed [15:0] loopOut_reg, loopOut_next;
  logic signed [15:0] freqDemand_reg, freqDemand_next;
  logic signed [15:0] spClamped;

  always_comb begin
    longint sp;
    longint err;
    longint lim;
    longint iNew;
    longint dF;
    longint dem;
    longint mag;
    sp  = longint'(speedSetpoint);
    lim = longint'(loopCfg.limit);
    mag = 0;
    if (minMode == ssc_pkg::MIN_LINEAR) begin
      if (minSpeed < 0) begin
        sp = 0;
      end else begin
        sp = clampL(sp, 0, longint'(ssc_pkg::FULL_SCALE));
        sp = longint'(minSpeed) + ((sp * (longint'(ssc_pkg::FULL_SCALE) - longint'(minSpeed)))
             >>> ssc_pkg::FS_BITS);
      end
    end else begin
      sp = clampL(sp, longint'(minSpeed), longint'(ssc_pkg::FULL_SCALE));
    end
    spClamped = 16'(sp);
    err  = sp - longint'(speedFeedback);
    iNew = (loopCfg.ki == 16'h0000) ? 0 :
           clampL(longint'(intAcc_reg) + ((err * longint'(loopCfg.ki)) >>> ssc_pkg::GAIN_FRAC),
                  -lim, lim);
    dF   = longint'(dFilt_reg)
         + (((err - longint'(errPrev_reg)) - longint'(dFilt_reg)) >>> ssc_pkg::DFILT_SHIFT);
    dem  = ((err * longint'(loopCfg.kp)) >>> ssc_pkg::GAIN_FRAC)
         + iNew
         + ((dF * longint'(loopCfg.kd)) >>> ssc_pkg::GAIN_FRAC);
    dem  = clampL(dem, -lim, lim);
    intAcc_next     = intAcc_reg;
    errPrev_next    = errPrev_reg;
    dFilt_next      = dFilt_reg;
    loopOut_next    = loopOut_reg;
    freqDemand_next = freqDemand_reg;
    if (tick_reg) begin
      if (loopEnable) begin
        intAcc_next  = 16'(iNew);
        errPrev_next = 17'(err);
        dFilt_next   = 18'(clampL(dF, -131072, 131071));
        loopOut_next = 16'(dem);
      end else begin
        intAcc_next  = 16'sh0000;
        errPrev_next = 17'sh0_0000;
        dFilt_next   = 18'sh0_0000;
        loopOut_next = 16'sh0000;
        dem          = sp;
      end
      mag = (dem < 0) ? -dem : dem;
      mag = clampL(skipMag(skipMag(mag, skipCfg[0]), skipCfg[1]), 0,
                   longint'(ssc_pkg::MAG_MAX));
      freqDemand_next = 16'((dem < 0) ? -mag : mag);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      intAcc_reg     <= 16'sh0000;
      errPrev_reg    <= 17'sh0_0000;
      dFilt_reg      <= 18'sh0_0000;
      loopOut_reg    <= 16'sh0000;
      freqDemand_reg <= 16'sh0000;
    end else begin
      intAcc_reg     <= intAcc_next;
      errPrev_reg    <= errPrev_next;
      dFilt_reg      <= dFilt_next;
      loopOut_reg    <= loopOut_next;
      freqDemand_reg <= freqDemand_next;
    end
  end

  // ****************************************************************
  // Auto restart supervision
  // ****************************************************************
  ssc_pkg::ssc_rst_state_t state_reg, state_next;
  logic [3:0]  count_reg, count_next;
  logic [15:0] delayCnt_reg, delayCnt_next;
  logic [19:0] freeCnt_reg, freeCnt_next;
  logic        autoRst_reg, autoRst_next;
  logic        tripped_reg, tripped_next;
  logic        freeDone;

  always_comb begin
    longint thr;
    thr = longint'(ssc_pkg::DELAY_MULT) * longint'(restartCfg.delayMs);
    if (thr < longint'(ssc_pkg::CLEAR_MIN_MS)) thr = longint'(ssc_pkg::CLEAR_MIN_MS);
    freeDone      = (longint'(freeCnt_reg) >= thr);
    state_next    = state_reg;
    count_next    = count_reg;
    delayCnt_next = delayCnt_reg;
    autoRst_next  = 1'b0;
    freeCnt_next  = (state_reg == ssc_pkg::ST_RUN && runInput && !freeDone && ms_reg) ?
                    freeCnt_reg + 20'h0_0001 : freeCnt_reg;
    if (state_reg != ssc_pkg::ST_RUN || !runInput) freeCnt_next = 20'h0_0000;
    if (!runInput || (state_reg == ssc_pkg::ST_RUN && freeDone)) count_next = 4'h0;
    unique case (state_reg)
      ssc_pkg::ST_RUN: begin
        if (tripEvent) begin
          freeCnt_next = 20'h0_0000;
          if (tripSelected && restartCfg.enable && count_reg < restartCfg.maxAttempts) begin
            state_next    = ssc_pkg::ST_WAIT;
            count_next    = count_reg + 4'h1;
            delayCnt_next = 16'h0000;
          end else begin
            state_next = ssc_pkg::ST_LOCK;
          end
        end
      end
      ssc_pkg::ST_WAIT: begin
        if (tripResetReq) begin
          state_next = ssc_pkg::ST_RUN;
          count_next = 4'h0;
        end else if (delayCnt_reg >= restartCfg.delayMs) begin
          state_next   = ssc_pkg::ST_RUN;
          autoRst_next = 1'b1;
        end else if (ms_reg) begin
          delayCnt_next = delayCnt_reg + 16'h0001;
        end
      end
      ssc_pkg::ST_LOCK: begin
        if (tripResetReq) begin
          state_next = ssc_pkg::ST_RUN;
          count_next = 4'h0;
        end
      end
      default: state_next = ssc_pkg::ST_LOCK;
    endcase
    tripped_next = (state_next != ssc_pkg::ST_RUN);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg    <= ssc_pkg::ST_RUN;
      count_reg    <= 4'h0;
      delayCnt_reg <= 16'h0000;
      freeCnt_reg  <= 20'h0_0000;
      autoRst_reg  <= 1'b0;
      tripped_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      delayCnt_reg <= delayCnt_next;
      freeCnt_reg  <= freeCnt_next;
      autoRst_reg  <= autoRst_next;
      tripped_reg  <= tripped_next;
    end
  end

  // ****************************************************************
  // Power-up keys and default frequency
  // ****************************************************************
  logic       pwrDone_reg, pwrDone_next;
  logic       menu_reg, menu_next;
  logic [7:0] menuEntry_reg, menuEntry_next;
  logic       restore_reg, restore_next;
  logic [7:0] baseFreq_reg, baseFreq_next;
  logic [7:0] maxSpeed_reg, maxSpeed_next;
  logic [9:0] volts_reg, volts_next;

  // Keys are read once, at the first edge after reset, like a strap.
  always_comb begin
    pwrDone_next   = 1'b1;
    menu_next      = menu_reg;
    menuEntry_next = menuEntry_reg;
    restore_next   = 1'b0;
    baseFreq_next  = baseFreq_reg;
    maxSpeed_next  = maxSpeed_reg;
    volts_next     = volts_reg;
    if (!pwrDone_reg) begin
      volts_next = build400V ? ssc_pkg::VOLT_400 : ssc_pkg::VOLT_230;
      if (keyStop && keyDown) begin
        menu_next      = 1'b1;
        menuEntry_next = ssc_pkg::MENU_FIRST;
      end
      if (keyUp && keyDown) begin
        restore_next  = 1'b1;
        baseFreq_next = defaultFreqSel ? ssc_pkg::FREQ_60HZ : ssc_pkg::FREQ_50HZ;
        maxSpeed_next = defaultFreqSel ? ssc_pkg::FREQ_60HZ : ssc_pkg::FREQ_50HZ;
        if (build400V && defaultFreqSel) volts_next = ssc_pkg::VOLT_460;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwrDone_reg   <= 1'b0;
      menu_reg      <= 1'b0;
      menuEntry_reg <= ssc_pkg::MENU_NONE;
      restore_reg   <= 1'b0;
      baseFreq_reg  <= ssc_pkg::FREQ_50HZ;
      maxSpeed_reg  <= ssc_pkg::FREQ_50HZ;
      volts_reg     <= 10'h000;
    end else begin
      pwrDone_reg   <= pwrDone_next;
      menu_reg      <= menu_next;
      menuEntry_reg <= menuEntry_next;
      restore_reg   <= restore_next;
      baseFreq_reg  <= baseFreq_next;
      maxSpeed_reg  <= maxSpeed_next;
      volts_reg     <= volts_next;
    end
  end

  assign freqDemand      = freqDemand_reg;
  assign tripped         = tripped_reg;
  assign autoResetPulse  = autoRst_reg;
  assign restartCount    = count_reg;
  assign protectedMenu   = menu_reg;
  assign menuEntry       = menuEntry_reg;
  assign restoreDefaults = restore_reg;
  assign baseFreqHz      = baseFreq_reg;
  assign maxSpeedHz      = maxSpeed_reg;
  assign motorVolts      = volts_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic signed [16:0] demMag;
  longint             skipLo1, skipHi1;
  assign demMag  = (freqDemand_reg < 0) ? -17'(freqDemand_reg) : 17'(freqDemand_reg);
  assign skipLo1 = longint'(skipCfg[1].centre) - longint'(skipCfg[1].width >> 1);
  assign skipHi1 = longint'(skipCfg[1].centre) + longint'(skipCfg[1].width >> 1);

  sequence sRetryTaken;
    state_reg == ssc_pkg::ST_RUN && tripEvent && tripSelected && restartCfg.enable
      && count_reg < restartCfg.maxAttempts;
  endsequence
  sequence sRestorePulse;
    restoreDefaults ##1 !restoreDefaults;
  endsequence

  AST_DEMAND_TICK: assert property (!tick_reg |=> $stable(freqDemand_reg))
    else $error("Demand changed off the control tick.");
  AST_LIMIT: assert property (tick_reg && loopEnable |=>
    loopOut_reg <= $signed({1'b0, $past(loopCfg.limit)})
    && loopOut_reg >= -$signed({1'b0, $past(loopCfg.limit)}))
    else $error("Loop output outside the symmetric limit.");
  AST_SKIP: assert property (tick_reg && $stable(skipCfg) && skipCfg[1].centre != 16'h0000
    && skipCfg[1].width != 16'h0000 && skipHi1 <= 32767 |=>
    !(longint'(demMag) > skipLo1 && longint'(demMag) < skipHi1))
    else $error("Demand magnitude left inside a skip band.");
  AST_LOCK: assert property (state_reg == ssc_pkg::ST_RUN && tripEvent && !tripSelected
    |=> (tripped && state_reg == ssc_pkg::ST_LOCK) [*2])
    else $error("Unselected trip did not lock.");
  AST_RETRY: assert property (sRetryTaken |=> state_reg == ssc_pkg::ST_WAIT
    && restartCount == $past(restartCount) + 4'h1)
    else $error("Selected trip did not start a counted retry.");
  AST_RUN_CLR: assert property (!runInput && !(state_reg == ssc_pkg::ST_RUN && tripEvent
    && tripSelected && restartCfg.enable && count_reg < restartCfg.maxAttempts)
    |=> restartCount == 4'h0)
    else $error("Run removal did not clear the attempt count.");
  AST_MANUAL: assert property (state_reg != ssc_pkg::ST_RUN && tripResetReq
    |=> !tripped && restartCount == 4'h0)
    else $error("Manual trip reset did not clear trip and count.");
  AST_FREE_CLR: assert property (state_reg == ssc_pkg::ST_RUN && runInput && freeDone
    && !tripEvent |=> restartCount == 4'h0)
    else $error("Trip-free period did not clear the attempt count.");
  AST_MENU: assert property (!pwrDone_reg && keyStop && keyDown
    |=> protectedMenu && menuEntry == ssc_pkg::MENU_FIRST)
    else $error("Protected menu not entered at its first entry.");
  AST_RESTORE: assert property (!pwrDone_reg && keyUp && keyDown |=> sRestorePulse)
    else $error("Restore pulse not one cycle.");
  AST_DEFAULTS: assert property (!pwrDone_reg && keyUp && keyDown |=>
    baseFreqHz == ($past(defaultFreqSel) ? ssc_pkg::FREQ_60HZ : ssc_pkg::FREQ_50HZ)
    && motorVolts == (($past(build400V) && $past(defaultFreqSel)) ? ssc_pkg::VOLT_460 :
                      ($past(build400V) ? ssc_pkg::VOLT_400 : ssc_pkg::VOLT_230)))
    else $error("Frequency dependent defaults wrong.");
  AST_LIN_NEG: assert property (minMode == ssc_pkg::MIN_LINEAR && minSpeed < 0
    |-> spClamped == 16'sh0000)
    else $error("Linear mode with negative minimum not zero.");

endmodule : ssc_core

// file: bench/ssc_motor_model.sv
module ssc_motor_model (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic signed [15:0] fbLevel,
  input  wire logic [2:0]         keysHeld,
  output logic signed [15:0]      speedFeedback,
  output logic                    keyStop,
  output logic                    keyDown,
  output logic                    keyUp
);
  timeunit 1ns;
  timeprecision 100ps;

  // The stage reports the settled speed one cycle late, never a partial value.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      speedFeedback <= '0;
    end else begin
      speedFeedback <= fbLevel;
    end
  end

  assign {keyStop, keyDown, keyUp} = keysHeld;
endmodule : ssc_motor_model

// file: bench/tb_speed_setpoint_conditioner.sv
module tb_speed_setpoint_conditioner;
  timeunit 1ns;
  timeprecision 100ps;

  logic                         clk_sys = 1'b0;
  logic                         reset = 1'b1;
  logic signed [15:0]           speedSetpoint = '0, minSpeed = '0, fbLevel = '0;
  logic                         loopEnable = 1'b0, runInput = 1'b1, tripEvent = 1'b0;
  logic                         tripSelected = 1'b0, tripResetReq = 1'b0;
  logic                         defaultFreqSel = 1'b0, build400V = 1'b0, seenPulse;
  logic [2:0]                   keysHeld = '0;
  ssc_pkg::ssc_loop_cfg_t       loopCfg = '0;
  ssc_pkg::ssc_min_mode_t       minMode = ssc_pkg::MIN_PROP;
  ssc_pkg::ssc_skip_cfg_t [1:0] skipCfg = '0;
  ssc_pkg::ssc_restart_cfg_t    restartCfg = '0;
  logic signed [15:0]           speedFeedback, freqDemand;
  logic                         keyStop, keyDown, keyUp, tripped, autoResetPulse;
  logic                         protectedMenu, restoreDefaults;
  logic [3:0]                   restartCount;
  logic [7:0]                   menuEntry, baseFreqHz, maxSpeedHz;
  logic [9:0]                   motorVolts;
  int                           num_errors = 0, check_count = 0;

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  ssc_motor_model motor_u (.clk_sys, .reset, .fbLevel, .keysHeld, .speedFeedback,
    .keyStop, .keyDown, .keyUp);

  // A ten-cycle millisecond keeps the restart delays to about ten cycles.
  ssc_core #(.MS_CYCLES(10)) dut_u (.clk_sys, .reset, .speedSetpoint, .speedFeedback,
    .loopEnable, .loopCfg, .minSpeed, .minMode, .skipCfg, .restartCfg, .runInput,
    .tripEvent, .tripSelected, .tripResetReq, .keyStop, .keyDown, .keyUp, .defaultFreqSel,
    .build400V, .freqDemand, .tripped, .autoResetPulse, .restartCount, .protectedMenu,
    .menuEntry, .restoreDefaults, .baseFreqHz, .maxSpeedHz, .motorVolts);

  // ********************************
  // Shared tasks
  // ********************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset(input logic [2:0] keys, input logic fsel, input logic b400);
    @(posedge clk_sys);
    reset <= 1'b1;
    keysHeld <= keys;
    defaultFreqSel <= fsel;
    build400V <= b400;
    repeat (16) @(posedge clk_sys);
    #1;
    check(freqDemand, 16'h0000);
    check(16'(restartCount), 16'h0000);
    @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : do_reset

  // Waits a little over one tick, so at least one tick has seen the new inputs.
  task automatic demand(input logic [15:0] sp, input logic [15:0] mn,
                        input ssc_pkg::ssc_min_mode_t md, input logic [15:0] exp);
    @(posedge clk_sys);
    speedSetpoint <= sp;
    minSpeed <= mn;
    minMode <= md;
    repeat (1300) @(posedge clk_sys);
    #1;
    check(freqDemand, exp);
  endtask : demand

  task automatic wait_change();
    logic [15:0] old;
    old = freqDemand;
    for (int i = 0; i < 1300 && freqDemand === old; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : wait_change

  task automatic trip(input logic sel);
    @(posedge clk_sys);
    tripEvent <= 1'b1;
    tripSelected <= sel;
    @(posedge clk_sys);
    tripEvent <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : trip

  task automatic clear_trip();
    @(posedge clk_sys);
    tripResetReq <= 1'b1;
    @(posedge clk_sys);
    tripResetReq <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : clear_trip

  task automatic wait_auto(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(posedge clk_sys);
      #1;
      seen = (autoResetPulse === 1'b1);
    end
  endtask : wait_auto

  task automatic loop_start(input logic [15:0] kp, input logic [15:0] ki,
                            input logic [15:0] kd, input logic [15:0] fb);
    // Feedback is settled while the loop is idle, since the stage reports it a cycle late.
    @(posedge clk_sys);
    fbLevel <= fb;
    demand(16'h0800, 16'hC000, ssc_pkg::MIN_PROP, 16'h0800);
    @(posedge clk_sys);
    loopCfg <= '{kp: kp, ki: ki, kd: kd, limit: 15'h3000};
    loopEnable <= 1'b1;
    wait_change();
  endtask : loop_start

  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    do_reset(3'b011, 1'b1, 1'b1);
    check(16'(restoreDefaults), 16'h0001);
    check(16'(baseFreqHz), 16'h003C);
    check(16'(maxSpeedHz), 16'h003C);
    check(16'(motorVolts), 16'h01CC);
    do_reset(3'b110, 1'b0, 1'b0);
    check(16'(protectedMenu), 16'h0001);
    check(16'(menuEntry), 16'h0001);
    check(16'(motorVolts), 16'h00E6);
    do_reset(3'b011, 1'b0, 1'b1);
    check(16'(baseFreqHz), 16'h0032);
    check(16'(motorVolts), 16'h0190);
    check(16'(protectedMenu), 16'h0000);
    @(posedge clk_sys);
    keysHeld <= '0;
    demand(16'h0400, 16'h0800, ssc_pkg::MIN_PROP, 16'h0800);
    demand(16'h5000, 16'h0800, ssc_pkg::MIN_PROP, 16'h4000);
    demand(16'h2000, 16'h1000, ssc_pkg::MIN_LINEAR, 16'h2800);
    demand(16'hF000, 16'h1000, ssc_pkg::MIN_LINEAR, 16'h1000);
    demand(16'h2000, 16'hF000, ssc_pkg::MIN_LINEAR, 16'h0000);
    @(posedge clk_sys);
    skipCfg[0] <= '{centre: 16'h2000, width: 16'h0400};
    skipCfg[1] <= '{centre: 16'h3000, width: 16'h0000};
    demand(16'h1F00, 16'hC000, ssc_pkg::MIN_PROP, 16'h1E00);
    demand(16'hDF00, 16'hC000, ssc_pkg::MIN_PROP, 16'hDE00);
    demand(16'h2F00, 16'hC000, ssc_pkg::MIN_PROP, 16'h2F00);
    @(posedge clk_sys);
    skipCfg[0] <= '{centre: 16'h0000, width: 16'h0400};
    skipCfg[1] <= '{centre: 16'h3000, width: 16'h0400};
    demand(16'h3100, 16'hC000, ssc_pkg::MIN_PROP, 16'h3200);
    demand(16'h2100, 16'hC000, ssc_pkg::MIN_PROP, 16'h2100);
    @(posedge clk_sys);
    skipCfg <= '0;
    fbLevel <= 16'h0800;
    loopCfg <= '{kp: 16'h0200, ki: 16'h0000, kd: 16'h0000, limit: 15'h0C00};
    loopEnable <= 1'b1;
    demand(16'h1000, 16'hC000, ssc_pkg::MIN_PROP, 16'h0C00);
    demand(16'h0000, 16'hC000, ssc_pkg::MIN_PROP, 16'hF400);
    @(posedge clk_sys);
    loopCfg.kp <= 16'h0080;
    demand(16'h1000, 16'hC000, ssc_pkg::MIN_PROP, 16'h0400);
    @(posedge clk_sys);
    loopEnable <= 1'b0;
    loop_start(16'h0000, 16'h0100, 16'h0000, 16'h0700);
    check(freqDemand, 16'h0100);
    repeat (1249) @(posedge clk_sys);
    #1;
    check(freqDemand, 16'h0100);
    @(posedge clk_sys);
    #1;
    check(freqDemand, 16'h0200);
    @(posedge clk_sys);
    loopEnable <= 1'b0;
    loop_start(16'h0000, 16'h0000, 16'h0100, 16'h0000);
    check(freqDemand, 16'h0100);
    repeat (1250) @(posedge clk_sys);
    #1;
    check(freqDemand, 16'h00E0);
    @(posedge clk_sys);
    restartCfg <= '{enable: 1'b1, maxAttempts: 4'h2, delayMs: 16'h0001};
    trip(1'b1);
    check(16'(tripped), 16'h0001);
    check(16'(restartCount), 16'h0001);
    wait_auto(seenPulse);
    check(16'(seenPulse), 16'h0001);
    check(16'(tripped), 16'h0000);
    trip(1'b1);
    check(16'(restartCount), 16'h0002);
    wait_auto(seenPulse);
    check(16'(seenPulse), 16'h0001);
    trip(1'b1);
    wait_auto(seenPulse);
    check(16'(seenPulse), 16'h0000);
    check(16'(tripped), 16'h0001);
    clear_trip();
    check(16'(tripped), 16'h0000);
    check(16'(restartCount), 16'h0000);
    trip(1'b1);
    wait_auto(seenPulse);
    @(posedge clk_sys);
    runInput <= 1'b0;
    repeat (2) @(posedge clk_sys);
    runInput <= 1'b1;
    #1;
    check(16'(restartCount), 16'h0000);
    trip(1'b0);
    wait_auto(seenPulse);
    check(16'(seenPulse), 16'h0000);
    clear_trip();
    check(16'(tripped), 16'h0000);
    finish_test();
  end
endmodule : tb_speed_setpoint_conditioner
